//--- hdl/tdm_consts.svh
// Constants of the stream rate and mode selector: offsets, fields, counts.
// Assumes a 100 MHz system clock and an 8.192 MHz backplane frame clock.
// Operation
// - Test reset low forces the test controller to its reset state, without any clock.
// - Backplane runs 8.192 Mb/s with 128 channels or 16.384 Mb/s with 256.
// - Sub-rate 2-bit or 4-bit channels exist only for a 2 Mb/s local group.
// - Frame boundary is the frame clock rising edge seen while the pulse is low.
// - Backplane rate and local group modes decode independently of each other.
// - Rate bit 0 uses backplane streams 0-31; bit 1 uses only streams 0-15.
// - Groups: 0-3, 4-7, 8-11, 12-15 and 16-27, each set on its own.
// - Every stream of a group runs in that group's single mode.
// - Groups 0-3: codes 000 8M, 001 4M, 010 2M, 011 4-bit, 100 2-bit.
// - Group 4: 00 8M, 01 4M, 10 2M; all twelve pairs usable at 2M.
// - Group 4 at 4M or 8M carries data only on streams 16 to 18.
// - Group 4 at 4M or 8M drives outputs 19 to 27 low.
// - Group 4 has no sub-rate mode.
// - Message mode lets the host read input slots and write output slots.
// - Each channel picks constant delay for data or variable delay for voice.
`ifndef TDM_CONSTS_SVH
`define TDM_CONSTS_SVH
// Register offsets
`define REG_MODE      4'h0
`define REG_CONTROL   4'h1
`define REG_STATUS    4'h2
`define REG_MSG_OUT   4'h3
`define REG_MSG_IN    4'h4
`define REG_DELAY     4'h5
// Mode register fields
`define MODE_BP_BIT   0
`define MODE_G0_LSB   1
`define MODE_G4_LSB   13
`define MODE_WIDTH    15
`define MODE_RESET    15'h0000
// Control fields
`define CTRL_CLK_SEL  0
`define CTRL_MSG_EN   1
// Delay register: channel in low byte, choice in bit 8
`define DELAY_VAL_BIT 8
// Stream counts
`define LOCAL_STREAMS 28
`define BP_STREAMS    32
`define BP_HALF       16
`define G4_FIRST      16
`define G4_FAST_LAST  18
// Frame timing
`define FRAME_NS      125000
`define LINK_KHZ      8192
`define BITS_PER_FRAME ((`FRAME_NS * `LINK_KHZ) / 1000000)
`define FRAME_PULSE_NS 122
`endif

//--- hdl/tdm_pkg.sv
// Types shared by the stream rate and mode selector.
// Assumes the constants header is included by the design file.
package tdm_pkg;
  typedef enum logic [1:0] {
    AL_SEARCH = 2'b01,
    AL_LOCKED = 2'b10
  } align_state_t;
  typedef enum logic [15:0] {
    T_RESET  = 16'h0001, T_IDLE   = 16'h0002,
    T_SELDR  = 16'h0004, T_CAPDR  = 16'h0008,
    T_SHDR   = 16'h0010, T_EX1DR  = 16'h0020,
    T_PADR   = 16'h0040, T_EX2DR  = 16'h0080,
    T_UPDR   = 16'h0100, T_SELIR  = 16'h0200,
    T_CAPIR  = 16'h0400, T_SHIR   = 16'h0800,
    T_EX1IR  = 16'h1000, T_PAIR   = 16'h2000,
    T_EX2IR  = 16'h4000, T_UPIR   = 16'h8000
  } tap_state_t;
endpackage : tdm_pkg

//--- hdl/tdm_stream_rate_mode_select.sv
// Stream rate and mode selector with frame alignment and message buffer.
// Assumes pins are asynchronous to clock; core-side ports share clock.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_consts.svh"

// Small FIFO with registered flags
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem_q[rp_q];

  // Next fill level
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    if (pop && !push) cnt_d = cnt_q - 1'b1;
  end

  // Storage and pointers
  always_ff @(posedge clock) begin
    if (push) mem_q[wp_q] <= in_data;
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
  end

  // Level and flags
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != (AW+1)'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : msg_fifo

module tdm_stream_rate_mode_select
  import tdm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Backplane frame timing pins
  input  wire logic        frame_clock_a,
  input  wire logic        frame_clock_b,
  input  wire logic        frame_pulse_a_n,
  input  wire logic        frame_pulse_b_n,
  // Backplane streams, two-way
  input  wire logic [31:0] backplane_stream_in,
  output logic      [31:0] backplane_stream_out,
  output logic      [31:0] backplane_stream_oe_n,
  // Local stream pins
  input  wire logic [27:0] local_stream_in,
  output logic      [27:0] local_stream_out,
  // Switch core side
  input  wire logic [31:0] core_bp_out,
  input  wire logic [31:0] core_bp_drive,
  output logic      [31:0] core_bp_in,
  input  wire logic [27:0] core_local_out,
  output logic      [27:0] core_local_in,
  output logic             frame_start,
  output logic      [9:0]  frame_bit,
  output logic      [7:0]  channel,
  output logic             channel_const_delay,
  output logic             backplane_fast,
  output logic      [9:0]  group_rate,
  output logic      [7:0]  group_subrate,
  input  wire logic [7:0]  msg_in_data,
  input  wire logic        msg_in_strobe,
  output logic             msg_out_valid,
  input  wire logic        msg_out_ready,
  output logic      [7:0]  msg_out_data,
  // Test access pins
  input  wire logic        test_clock,
  input  wire logic        test_mode_sel,
  input  wire logic        test_reset_n,
  output logic             test_logic_reset
);
  logic [`MODE_WIDTH-1:0] mode_q;
  logic [1:0]        ctrl_q;
  logic [3:0]        tsync1_q;
  logic [3:0]        tsync2_q;
  logic              clk_prev_q;
  logic              sel_clk;
  logic              sel_pulse_n;
  logic              clk_rise;
  logic              boundary;
  align_state_t      align_q;
  logic              misalign_q;
  logic [9:0]        bit_q;
  logic [27:0]       loc_sync1_q;
  logic [27:0]       loc_sync2_q;
  logic [31:0]       bp_sync1_q;
  logic [31:0]       bp_sync2_q;
  logic [27:0]       loc_en;
  logic [31:0]       bp_en;
  logic [4:0]        grp_bad;
  logic              delay_mem_q [256];
  logic [7:0]        msg_in_q;
  logic              msg_in_valid_q;
  logic              overflow_q;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [7:0]        fifo_out_data;
  logic [1:0]        tck_sync1_q;
  logic [1:0]        tck_sync2_q;
  logic              tck_prev_q;
  tap_state_t        tap_q;
  tap_state_t        tap_d;
  logic              hit_write;

  // Three-bit mode field of groups 0-3
  function automatic logic [2:0] grp_code(input logic [`MODE_WIDTH-1:0] m, input int g);
    grp_code = m[`MODE_G0_LSB + 3*g +: 3];
  endfunction : grp_code

  // Group that owns a local stream pair
  function automatic int grp_of(input int s);
    grp_of = (s < `G4_FIRST) ? s / 4 : 4;
  endfunction : grp_of

  // Channel number from bit position and backplane rate
  function automatic logic [7:0] chan_of(input logic [9:0] b, input logic fast);
    chan_of = fast ? b[9:2] : {1'b0, b[9:3]};
  endfunction : chan_of

  assign hit_write = reg_write && (reg_addr == `REG_MSG_OUT);
  assign fifo_in_valid = hit_write;

  // Mode and control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= `MODE_RESET;
      ctrl_q <= '0;
    end else if (reg_write) begin
      if (reg_addr == `REG_MODE) mode_q <= reg_wdata[`MODE_WIDTH-1:0];
      if (reg_addr == `REG_CONTROL) ctrl_q <= reg_wdata[1:0];
    end
  end

  // Per-channel delay choice store
  always_ff @(posedge clock) begin
    if (reg_write && reg_addr == `REG_DELAY)
      delay_mem_q[reg_wdata[7:0]] <= reg_wdata[`DELAY_VAL_BIT];
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_MODE:    reg_rdata <= {1'b0, mode_q};
        `REG_CONTROL: reg_rdata <= {14'h0000, ctrl_q};
        `REG_STATUS:  reg_rdata <= {6'h00, grp_bad, misalign_q, overflow_q,
                                    msg_in_valid_q, ~fifo_in_ready, align_q == AL_LOCKED};
        `REG_MSG_IN:  reg_rdata <= {8'h00, msg_in_q};
        `REG_DELAY:   reg_rdata <= {8'h00, channel};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Captured input slot for the host; a new capture beats the read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      msg_in_q       <= '0;
      msg_in_valid_q <= 1'b0;
    end else if (msg_in_strobe && ctrl_q[`CTRL_MSG_EN]) begin
      msg_in_q       <= msg_in_data;
      msg_in_valid_q <= 1'b1;
    end else if (reg_read && reg_addr == `REG_MSG_IN) begin
      msg_in_valid_q <= 1'b0;
    end
  end

  // Overflow flag: push while full; set wins over clear by status read
  always_ff @(posedge clock) begin
    if (rst) overflow_q <= 1'b0;
    else if (hit_write && !fifo_in_ready) overflow_q <= 1'b1;
    else if (reg_read && reg_addr == `REG_STATUS) overflow_q <= 1'b0;
  end

  // Output slot data from host toward the core
  msg_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (reg_wdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (msg_out_ready & ctrl_q[`CTRL_MSG_EN]),
    .out_data  (fifo_out_data)
  );
  assign msg_out_valid = fifo_out_valid & ctrl_q[`CTRL_MSG_EN];
  assign msg_out_data  = fifo_out_data;

  // Two-flop capture of frame clocks and pulses; frame clock is ~8.192 MHz
  always_ff @(posedge clock) begin
    if (rst) begin
      tsync1_q <= 4'hf;
      tsync2_q <= 4'hf;
    end else begin
      tsync1_q <= {frame_pulse_b_n, frame_pulse_a_n, frame_clock_b, frame_clock_a};
      tsync2_q <= tsync1_q;
    end
  end

  // Chosen clock and pulse; the pulse spans about 122 ns of clock
  assign sel_clk     = ctrl_q[`CTRL_CLK_SEL] ? tsync2_q[1] : tsync2_q[0];
  assign sel_pulse_n = ctrl_q[`CTRL_CLK_SEL] ? tsync2_q[3] : tsync2_q[2];
  assign clk_rise    = sel_clk & ~clk_prev_q;
  assign boundary    = clk_rise & ~sel_pulse_n;

  // Bit counter across the 125 us frame
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_prev_q  <= 1'b1;
      bit_q       <= '0;
      frame_start <= 1'b0;
    end else begin
      clk_prev_q  <= sel_clk;
      frame_start <= boundary;
      if (boundary) bit_q <= '0;
      else if (clk_rise) bit_q <= (bit_q == 10'(`BITS_PER_FRAME - 1)) ? '0 : bit_q + 1'b1;
    end
  end

  // Frame lock tracking; misplaced boundary drops lock
  always_ff @(posedge clock) begin
    if (rst) begin
      align_q    <= AL_SEARCH;
      misalign_q <= 1'b0;
    end else begin
      case (align_q)
        AL_SEARCH: if (boundary) align_q <= AL_LOCKED;
        AL_LOCKED: if (boundary && bit_q != 10'(`BITS_PER_FRAME - 1)) align_q <= AL_SEARCH;
        default:   align_q <= AL_SEARCH;
      endcase
      if (align_q == AL_LOCKED && boundary && bit_q != 10'(`BITS_PER_FRAME - 1))
        misalign_q <= 1'b1;
      else if (reg_read && reg_addr == `REG_STATUS)
        misalign_q <= 1'b0;
    end
  end

  // Channel position and its delay choice
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_bit           <= '0;
      channel             <= '0;
      channel_const_delay <= 1'b0;
    end else begin
      frame_bit           <= bit_q;
      channel             <= chan_of(bit_q, mode_q[`MODE_BP_BIT]);
      channel_const_delay <= delay_mem_q[chan_of(bit_q, mode_q[`MODE_BP_BIT])];
    end
  end

  // Group decode, backplane decode kept apart
  always_comb begin
    for (int g = 0; g < 4; g++)
      grp_bad[g] = grp_code(mode_q, g) > 3'h4;
    grp_bad[4] = mode_q[`MODE_G4_LSB +: 2] == 2'h3;
    for (int s = 0; s < `LOCAL_STREAMS; s++) begin
      loc_en[s] = ~grp_bad[grp_of(s)];
      if (grp_of(s) == 4 && s > `G4_FAST_LAST && mode_q[`MODE_G4_LSB +: 2] != 2'h2)
        loc_en[s] = 1'b0;
    end
    for (int b = 0; b < `BP_STREAMS; b++)
      bp_en[b] = ~mode_q[`MODE_BP_BIT] || (b < `BP_HALF);
  end

  // Rate and sub-rate per group to the core
  always_ff @(posedge clock) begin
    if (rst) begin
      group_rate     <= '0;
      group_subrate  <= '0;
      backplane_fast <= 1'b0;
    end else begin
      backplane_fast <= mode_q[`MODE_BP_BIT];
      for (int g = 0; g < 4; g++) begin
        case (grp_code(mode_q, g))
          3'h0: begin group_rate[2*g +: 2] <= 2'h0; group_subrate[2*g +: 2] <= 2'h0; end
          3'h1: begin group_rate[2*g +: 2] <= 2'h1; group_subrate[2*g +: 2] <= 2'h0; end
          3'h2: begin group_rate[2*g +: 2] <= 2'h2; group_subrate[2*g +: 2] <= 2'h0; end
          3'h3: begin group_rate[2*g +: 2] <= 2'h2; group_subrate[2*g +: 2] <= 2'h1; end
          3'h4: begin group_rate[2*g +: 2] <= 2'h2; group_subrate[2*g +: 2] <= 2'h2; end
          default: begin group_rate[2*g +: 2] <= 2'h3; group_subrate[2*g +: 2] <= 2'h0; end
        endcase
      end
      group_rate[9:8] <= mode_q[`MODE_G4_LSB +: 2];
    end
  end

  // Pin input capture
  always_ff @(posedge clock) begin
    if (rst) begin
      loc_sync1_q <= '0;
      loc_sync2_q <= '0;
      bp_sync1_q  <= '0;
      bp_sync2_q  <= '0;
    end else begin
      loc_sync1_q <= local_stream_in;
      loc_sync2_q <= loc_sync1_q;
      bp_sync1_q  <= backplane_stream_in;
      bp_sync2_q  <= bp_sync1_q;
    end
  end

  // Gated streams in both directions
  always_ff @(posedge clock) begin
    if (rst) begin
      core_local_in         <= '0;
      local_stream_out      <= '0;
      core_bp_in            <= '0;
      backplane_stream_out  <= '0;
      backplane_stream_oe_n <= '1;
    end else begin
      core_local_in         <= loc_sync2_q & loc_en;
      local_stream_out      <= core_local_out & loc_en;
      core_bp_in            <= bp_sync2_q & bp_en;
      backplane_stream_out  <= core_bp_out & bp_en;
      backplane_stream_oe_n <= ~(core_bp_drive & bp_en);
    end
  end

  // Test clock capture; clock assumed idle low when unused
  always_ff @(posedge clock) begin
    if (rst) begin
      tck_sync1_q <= '0;
      tck_sync2_q <= '0;
      tck_prev_q  <= 1'b0;
    end else begin
      tck_sync1_q <= {test_mode_sel, test_clock};
      tck_sync2_q <= tck_sync1_q;
      tck_prev_q  <= tck_sync2_q[0];
    end
  end

  // Test controller next state
  always_comb begin
    case (tap_q)
      T_RESET: tap_d = tck_sync2_q[1] ? T_RESET : T_IDLE;
      T_IDLE:  tap_d = tck_sync2_q[1] ? T_SELDR : T_IDLE;
      T_SELDR: tap_d = tck_sync2_q[1] ? T_SELIR : T_CAPDR;
      T_CAPDR: tap_d = tck_sync2_q[1] ? T_EX1DR : T_SHDR;
      T_SHDR:  tap_d = tck_sync2_q[1] ? T_EX1DR : T_SHDR;
      T_EX1DR: tap_d = tck_sync2_q[1] ? T_UPDR  : T_PADR;
      T_PADR:  tap_d = tck_sync2_q[1] ? T_EX2DR : T_PADR;
      T_EX2DR: tap_d = tck_sync2_q[1] ? T_UPDR  : T_SHDR;
      T_UPDR:  tap_d = tck_sync2_q[1] ? T_SELDR : T_IDLE;
      T_SELIR: tap_d = tck_sync2_q[1] ? T_RESET : T_CAPIR;
      T_CAPIR: tap_d = tck_sync2_q[1] ? T_EX1IR : T_SHIR;
      T_SHIR:  tap_d = tck_sync2_q[1] ? T_EX1IR : T_SHIR;
      T_EX1IR: tap_d = tck_sync2_q[1] ? T_UPIR  : T_PAIR;
      T_PAIR:  tap_d = tck_sync2_q[1] ? T_EX2IR : T_PAIR;
      T_EX2IR: tap_d = tck_sync2_q[1] ? T_UPIR  : T_SHIR;
      T_UPIR:  tap_d = tck_sync2_q[1] ? T_SELDR : T_IDLE;
      default: tap_d = T_RESET;
    endcase
  end

  // Test controller state, forced by test reset without a clock
  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tap_q            <= T_RESET;
      test_logic_reset <= 1'b1;
    end else if (rst) begin
      tap_q            <= T_RESET;
      test_logic_reset <= 1'b1;
    end else if (tck_sync2_q[0] && !tck_prev_q) begin
      tap_q            <= tap_d;
      test_logic_reset <= (tap_d == T_RESET);
    end
  end
endmodule : tdm_stream_rate_mode_select
`default_nettype wire

//--- testbench/tdm_stream_assertions.sv
// Port-level checker for the stream rate and mode selector.
// Assumes one clock domain with the synchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
module tdm_stream_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [31:0] backplane_stream_out,
  input wire logic [31:0] backplane_stream_oe_n,
  input wire logic [27:0] core_local_out,
  input wire logic [27:0] local_stream_out,
  input wire logic        frame_start,
  input wire logic [9:0]  frame_bit,
  input wire logic        backplane_fast,
  input wire logic [9:0]  group_rate,
  input wire logic [7:0]  group_subrate,
  input wire logic        test_reset_n,
  input wire logic        test_logic_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Group 4 stream gating by its rate
  chk_g4_upper_low: assert property ((group_rate[9:8] != 2'h2)[*3] |-> local_stream_out[27:19] == 9'h0)
    else $error("group 4 upper outputs not low");
  chk_g4_fast_pass: assert property ((group_rate[9:8] < 2'h2)[*3] |->
    local_stream_out[18:16] == $past(core_local_out[18:16]))
    else $error("group 4 low streams do not follow core");
  chk_g4_slow_pass: assert property ((group_rate[9:8] == 2'h2)[*3] |->
    local_stream_out[27:16] == $past(core_local_out[27:16]))
    else $error("group 4 streams do not follow core at 2M");
  // Reserved codes silence group 0; sub-rate only at the 2M rate
  chk_reserved_off: assert property ((group_rate[1:0] == 2'h3)[*3] |-> local_stream_out[3:0] == 4'h0)
    else $error("reserved group 0 outputs not low");
  chk_subrate_2m: assert property (group_subrate[1:0] != 2'h0 |-> group_rate[1:0] == 2'h2)
    else $error("sub-rate outside 2M");
  // Fast backplane releases upper streams; frame start gives bit zero; test reset forces reset
  chk_bp_upper_idle: assert property (backplane_fast[*3] |->
    backplane_stream_oe_n[31:16] == 16'hffff && backplane_stream_out[31:16] == 16'h0)
    else $error("upper backplane streams active at fast rate");
  chk_boundary_bit: assert property (frame_start |=> frame_bit == 10'h0 && !frame_start)
    else $error("frame start without bit zero");
  chk_test_reset: assert property (!test_reset_n |-> test_logic_reset)
    else $error("test controller not in reset");
endmodule : tdm_stream_assertions

bind tdm_stream_rate_mode_select tdm_stream_assertions i_chk (
  .clock, .rst, .backplane_stream_out, .backplane_stream_oe_n, .core_local_out,
  .local_stream_out, .frame_start, .frame_bit, .backplane_fast, .group_rate,
  .group_subrate, .test_reset_n, .test_logic_reset
);
`default_nettype wire

//--- testbench/backplane_partner.sv
// Backplane frame timing source and pin data for the selector.
// Assumes a free-running link clock; pulse only on side A.
`timescale 1ns/1ps
`default_nettype none
module backplane_partner #(
  parameter int HALF_NS    = 40,
  parameter int FRAME_BITS = 1024,
  parameter int PULSE_NS   = 122,
  parameter int LEAD_NS    = 60
) (
  output logic        frame_clock_a,
  output logic        frame_clock_b,
  output logic        frame_pulse_a_n,
  output logic        frame_pulse_b_n,
  output logic [31:0] backplane_stream_in,
  output logic [27:0] local_stream_in
);
  int bit_q;
  // Link clock and frame pulse; pin data change every bit
  initial begin
    frame_clock_a = 1'b0;
    frame_clock_b = 1'b0;
    frame_pulse_a_n = 1'b1;
    frame_pulse_b_n = 1'b1; // Side B never frames
    backplane_stream_in = 32'h5555aaaa;
    local_stream_in = 28'h5a5a5a5;
    bit_q = FRAME_BITS - 3;
    #3;
    forever begin
      #HALF_NS;
      frame_clock_a = 1'b1;
      frame_clock_b = 1'b1;
      bit_q = (bit_q + 1) % FRAME_BITS;
      // Pulse falls LEAD_NS before the boundary rise and stays low PULSE_NS, one rise inside
      if (bit_q == FRAME_BITS - 1) frame_pulse_a_n <= #(2 * HALF_NS - LEAD_NS) 1'b0;
      if (bit_q == 0) frame_pulse_a_n <= #(PULSE_NS - LEAD_NS) 1'b1;
      #HALF_NS;
      frame_clock_a = 1'b0;
      frame_clock_b = 1'b0;
      backplane_stream_in = ~backplane_stream_in;
      local_stream_in = ~local_stream_in;
    end
  end
endmodule : backplane_partner
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the stream rate and mode selector.
// Assumes the partner model supplies frame timing and pin data.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 1'b0, rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic        reg_write = 1'b0, reg_read = 1'b0;
  logic        frame_clock_a, frame_clock_b, frame_pulse_a_n, frame_pulse_b_n;
  logic [31:0] backplane_stream_in, backplane_stream_out, backplane_stream_oe_n;
  logic [27:0] local_stream_in, local_stream_out;
  logic [31:0] core_bp_out = 32'hffffffff, core_bp_drive = 32'hffffffff, core_bp_in;
  logic [27:0] core_local_out = 28'hfffffff, core_local_in;
  logic        frame_start, channel_const_delay, backplane_fast, msg_out_valid;
  logic [9:0]  frame_bit, group_rate;
  logic [7:0]  channel, group_subrate, msg_out_data, msg_in_data = 8'h0;
  logic        msg_in_strobe = 1'b0, msg_out_ready = 1'b0, test_logic_reset;
  logic        test_clock = 1'b0, test_mode_sel = 1'b1, test_reset_n = 1'b1;
  int          err_total = 0, checked = 0;

  tdm_stream_rate_mode_select i_dut (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .frame_clock_a, .frame_clock_b, .frame_pulse_a_n, .frame_pulse_b_n,
    .backplane_stream_in, .backplane_stream_out, .backplane_stream_oe_n,
    .local_stream_in, .local_stream_out, .core_bp_out, .core_bp_drive, .core_bp_in,
    .core_local_out, .core_local_in, .frame_start, .frame_bit, .channel,
    .channel_const_delay, .backplane_fast, .group_rate, .group_subrate, .msg_in_data,
    .msg_in_strobe, .msg_out_valid, .msg_out_ready, .msg_out_data, .test_clock,
    .test_mode_sel, .test_reset_n, .test_logic_reset
  );
  backplane_partner i_partner (
    .frame_clock_a, .frame_clock_b, .frame_pulse_a_n, .frame_pulse_b_n,
    .backplane_stream_in, .local_stream_in
  );

  // System clock, 100 MHz
  always #5 clock = ~clock;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  // Counts edges up to the next frame start, toggling core data meanwhile
  task automatic wait_frame(output int n);
    n = 0;
    do begin
      @(posedge clock);
      core_local_out <= ~core_local_out;
      #1 n++;
    end while (frame_start !== 1'b1 && n < 9000);
  endtask : wait_frame

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial begin
    #400000;
    err_total++;
    $display("[FAIL] watchdog expected finish seen timeout");
    finish_test();
  end

  // Main sequence
  initial begin
    logic [15:0] d;
    logic [14:0] m;
    logic [27:0] en;
    logic [9:0]  er;
    logic [7:0]  es, prev;
    int          n;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    reg_rd(4'h0, d);
    check("mode reset", 32'h0, d);
    // Every code of every group, with the backplane bit varied alongside
    for (int g = 0; g < 5; g++) begin
      for (int c = 0; c < ((g < 4) ? 8 : 4); c++) begin
        m = (g < 4) ? 15'(c) << (1 + 3 * g) : 15'(c) << 13;
        m[0] = c[0];
        reg_wr(4'h0, {1'b0, m});
        repeat (4) @(posedge clock);
        #1;
        er = 10'((g < 4) ? ((c < 3) ? c : ((c < 5) ? 2 : 3)) : c) << (2 * g);
        es = (g < 4) ? 8'((c == 3) ? 1 : ((c == 4) ? 2 : 0)) << (2 * g) : 8'h0;
        en = (g < 4 && c > 4) ? 28'h007ffff & ~(28'hf << (4 * g)) : 28'h007ffff;
        if (g == 4)
          en = (c == 2) ? 28'hfffffff : ((c == 3) ? 28'h000ffff : 28'h007ffff);
        check("group_rate", 32'(er), 32'(group_rate));
        check("group_subrate", 32'(es), 32'(group_subrate));
        check("local_out", 32'(en), 32'(local_stream_out));
        check("bp_fast", 32'(c[0]), 32'(backplane_fast));
        check("bp_out", c[0] ? 32'h0000ffff : 32'hffffffff, backplane_stream_out);
        check("bp_oe_n", c[0] ? 32'hffff0000 : 32'h0, backplane_stream_oe_n);
        check("local_in", 32'h1, 32'(core_local_in == (28'h5a5a5a5 & en) ||
              core_local_in == (28'ha5a5a5a & en)));
        check("bp_in", 32'h1, 32'(core_bp_in == (32'h5555aaaa & (c[0] ? 32'h0000ffff : 32'hffffffff)) ||
              core_bp_in == (32'haaaa5555 & (c[0] ? 32'h0000ffff : 32'hffffffff))));
      end
    end
    reg_wr(4'h0, 16'h4000);
    reg_wr(4'hf, 16'hffff);
    reg_rd(4'hf, d);
    check("unmapped", 32'h0, d);
    reg_rd(4'h0, d);
    check("mode kept", 32'h4000, d);
    // Frame alignment on side A, then loss on side B
    wait_frame(n);
    check("frame found", 32'h1, 32'(frame_start));
    wait_frame(n);
    check("frame gap", 32'd8192, n);
    reg_wr(4'h1, 16'h0003);
    wait_frame(n);
    check("frame on b", 32'd9000, n);
    reg_wr(4'h1, 16'h0002);
    // Message buffer filled past full, then drained
    for (int i = 1; i < 6; i++)
      reg_wr(4'h3, 16'(i * 17));
    reg_rd(4'h2, d);
    check("fifo full ovf", 32'h3, 32'({d[3], d[1]}));
    check("frame locked", 32'h1, 32'(d[0]));
    @(posedge clock);
    msg_out_ready <= 1'b1;
    #1;
    for (int i = 1; i < 5; i++) begin
      check("msg valid", 32'h1, 32'(msg_out_valid));
      check("msg data", 32'(i * 17), 32'(msg_out_data));
      @(posedge clock);
      #1;
    end
    repeat (2) @(posedge clock);
    #1 check("msg empty", 32'h0, 32'(msg_out_valid));
    reg_rd(4'h2, d);
    check("ovf cleared", 32'h0, 32'({d[3], d[1]}));
    @(posedge clock);
    msg_in_data <= 8'ha5;
    msg_in_strobe <= 1'b1;
    @(posedge clock);
    msg_in_strobe <= 1'b0;
    reg_rd(4'h4, d);
    check("msg_in", 32'ha5, 32'(d[7:0]));
    // Per-channel delay choice follows the channel counter
    for (int ch = 0; ch < 256; ch++)
      reg_wr(4'h5, {7'h0, ch[0], ch[7:0]});
    #1 prev = channel;
    repeat (2000) begin
      @(posedge clock);
      #1;
      if (channel === prev)
        check("const delay", 32'(channel[0]), 32'(channel_const_delay));
      prev = channel;
    end
    // Test controller leaves reset, then is reset without a clock
    @(posedge clock);
    test_mode_sel <= 1'b0;
    repeat (4) begin
      repeat (4) @(posedge clock);
      test_clock <= ~test_clock;
    end
    repeat (4) @(posedge clock);
    #1 check("tap idle", 32'h0, 32'(test_logic_reset));
    @(posedge clock);
    test_reset_n <= 1'b0;
    #2 check("tap async reset", 32'h1, 32'(test_logic_reset));
    repeat (2) @(posedge clock);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
